//--- src/sed_consts.svh
// Purpose: constants of the serial eeprom command decoder
// Assumes: 25 MHz system clock
// Notes: offsets are byte addresses on the register bus
`ifndef SED_CONSTS_SVH
`define SED_CONSTS_SVH

// ------------------------------------------------------------
// register map
// ------------------------------------------------------------
`define SED_OFS_CTRL 4'h0
`define SED_OFS_STATUS 4'h4
`define SED_OFS_GUARD 4'h8

// ------------------------------------------------------------
// reset values and field layout
// ------------------------------------------------------------
`define SED_VARIANT_RST 2'h2
`define SED_GUARD_ADDR_RST 8'hFF
`define SED_GUARD_FLAG_RST 1'h1
`define SED_VAR_NARROW 2'h0
`define SED_VAR_MEDIUM 2'h1
`define SED_MASK_NARROW 8'h3F
`define SED_MASK_MEDIUM 8'h7F
`define SED_MASK_WIDE 8'hFF
`define SED_LAST_HDR_NARROW 5'h07
`define SED_LAST_HDR_WIDE 5'h09
`define SED_LAST_DATA 5'h0F
`define SED_PAGE_WORDS 3'h4

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define SED_CLK_HZ 25000000
`define SED_T_PROG_MS 10
`define SED_PROG_CYCLES ((`SED_T_PROG_MS * `SED_CLK_HZ) / 1000)

`endif

//--- src/sed_pkg.sv
// Purpose: types of the serial eeprom command decoder
// Assumes: nothing beyond the constants header
// Notes: pin bundle is the carrier into the synchroniser
package sed_pkg;

   // ------------------------------------------------------------
   // serial pin bundle
   // ------------------------------------------------------------
   typedef struct packed {
      logic sel;
      logic sclk;
      logic sdi;
      logic guard_pin;
      logic permit;
   } sed_pins_t;

   // ------------------------------------------------------------
   // decoder states and instructions
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      st_idle,
      st_start,
      st_head,
      st_data,
      st_arm,
      st_read,
      st_wait,
      st_busy
   } sed_state_t;

   typedef enum logic [3:0] {
      no_cmd,
      read_cmd,
      write_cmd,
      page_program_cmd,
      fill_all_cmd,
      program_unlock_cmd,
      program_lock_cmd,
      guard_read_cmd,
      guard_set_cmd,
      guard_clear_cmd,
      guard_unlock_cmd,
      guard_freeze_cmd
   } sed_cmd_t;

endpackage

//--- src/sed_sync.sv
// Purpose: two-stage synchroniser for the serial pins
// Assumes: pins are asynchronous to clk_i
// Notes: first stage is read only by the second stage
module sed_sync
   import sed_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire sed_pins_t d_i,
   output sed_pins_t q_o
);

   localparam int W = $bits(sed_pins_t);
   logic [W-1:0] meta;
   logic [W-1:0] stable;

   // ------------------------------------------------------------
   // one synchroniser per pin
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < W; g++)
      begin : g_bit
         always_ff @(posedge clk_i)
         begin
            if (rst_i)
            begin
               meta[g] <= 1'b0;
               stable[g] <= 1'b0;
            end
            else
            begin
               meta[g] <= d_i[g];
               stable[g] <= meta[g];
            end
         end
      end
   endgenerate

   assign q_o = stable;

endmodule // sed_sync

//--- src/sed_top.sv
// Purpose: instruction front end of a word-wide three-wire serial eeprom
// Assumes: rst_i is the power-on clear; pins pass two flip-flops first
// Notes: serial clock is sampled, so it may run as slow as wanted
// What this block does
// - reset leaves device program-locked, no programming
// - first one sampled opens the instruction
// - two op-code bits, then the address
// - op-code 00 also decodes top address bits
// - address six or eight bits, msb first
// - state holds at any clock rate, even stopped
// - normal op-codes: read, write, page, fill, locks
// - guard op-codes: read, set, clear, unlock, freeze
// - medium variant ignores top address bit
// - read: dummy zero, then sixteen bits msb first
// - data out changes only on rising clock
// - select held high: next word follows
// - no dummy bit between sequential words
// - unlock holds until lock or power clear
// - guard set protects at and above address
// - busy drives zero, ready one; input ignored
// - guard unlock must immediately precede guard ops
//
// Chosen here: the Wishbone slave port and the address map.
`include "sed_consts.svh"

module sed_top
   import sed_pkg::*;
#(
   parameter int unsigned PROG_CYCLES = `SED_PROG_CYCLES
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic sel_i,
   input wire logic sclk_i,
   input wire logic sdi_i,
   input wire logic guard_pin_i,
   input wire logic permit_i,
   output logic sdo_o,
   output logic sdo_oe_n_o,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o
);

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   sed_pins_t pins_raw;
   sed_pins_t pins_s;
   logic sclk_q;
   logic rise;
   sed_state_t state;
   logic [4:0] cnt;
   logic [9:0] hdr;
   logic [9:0] next_hdr;
   logic [15:0] dat;
   logic [15:0] next_dat;
   logic [15:0] page_buf [0:3];
   logic [2:0] wcnt;
   sed_cmd_t cmd_q;
   sed_cmd_t cmd;
   logic [7:0] addr;
   logic [7:0] next_addr;
   logic [15:0] rd_word;
   logic [3:0] idx;
   logic rd_guard;
   logic sdo;
   logic sdo_oe_n;
   logic ready_show;
   logic [19:0] prog_cnt;
   logic unlocked;
   logic guard_flag;
   logic otp;
   logic armed;
   logic [7:0] guard_addr;
   logic [15:0] mem [0:255];
   logic [1:0] variant;
   logic wide;
   logic [7:0] amask;
   logic [4:0] last_hdr;
   logic [1:0] op;
   logic [7:0] a_in;
   logic top_ones;
   logic top_zeros;
   logic dec_fire;
   logic wt_ok;
   logic guard_ok;
   logic page_hit;
   logic commit;
   logic bus_req;

   // ------------------------------------------------------------
   // pin synchronisers and clock edge
   // ------------------------------------------------------------
   assign pins_raw = '{sel: sel_i, sclk: sclk_i, sdi: sdi_i, guard_pin: guard_pin_i, permit: permit_i};

   sed_sync u_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d_i (pins_raw),
      .q_o (pins_s)
   );

   // edge found on the stable copy only; nothing counts time between edges
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         sclk_q <= 1'b0;
      else
         sclk_q <= pins_s.sclk;
   end

   assign rise = pins_s.sclk & ~sclk_q;

   // ------------------------------------------------------------
   // address framing and instruction decode
   // ------------------------------------------------------------
   assign wide = (variant != `SED_VAR_NARROW);
   assign amask = !wide ? `SED_MASK_NARROW : (variant == `SED_VAR_MEDIUM) ? `SED_MASK_MEDIUM : `SED_MASK_WIDE;
   assign last_hdr = wide ? `SED_LAST_HDR_WIDE : `SED_LAST_HDR_NARROW;
   assign next_hdr = {hdr[8:0], pins_s.sdi};
   assign next_dat = {dat[14:0], pins_s.sdi};
   assign op = wide ? next_hdr[9:8] : next_hdr[7:6];
   assign a_in = wide ? next_hdr[7:0] : {2'h0, next_hdr[5:0]};
   assign top_ones = wide ? (a_in == 8'hFF) : (a_in[5:0] == 6'h3F);
   assign top_zeros = (a_in == 8'h00);
   assign dec_fire = (state == st_head) && rise && (cnt == last_hdr);
   assign wt_ok = unlocked & pins_s.permit;
   assign guard_ok = armed & wt_ok & ~otp;
   assign next_addr = (addr + 8'h01) & amask;

   // don't-care address bits reach only the guard clear and guard freeze compares below
   always_comb
   begin
      logic [1:0] top;
      top = wide ? a_in[7:6] : a_in[5:4];
      cmd = no_cmd;
      if (!pins_s.guard_pin)
      begin
         case (op)
            2'h2: cmd = read_cmd;
            2'h1: cmd = write_cmd;
            2'h3: cmd = page_program_cmd;
            default:
            begin
               if (top == 2'h1)
                  cmd = fill_all_cmd;
               else if (top == 2'h3)
                  cmd = program_unlock_cmd;
               else if (top == 2'h0)
                  cmd = program_lock_cmd;
            end
         endcase
      end
      else
      begin
         case (op)
            2'h2: cmd = guard_read_cmd;
            2'h1: cmd = guard_set_cmd;
            2'h3: cmd = top_ones ? guard_clear_cmd : no_cmd;
            default:
            begin
               if (top == 2'h3)
                  cmd = guard_unlock_cmd;
               else if (top_zeros)
                  cmd = guard_freeze_cmd;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // protection check at the moment select falls
   // ------------------------------------------------------------
   always_comb
   begin
      page_hit = 1'b0;
      for (int i = 0; i < 4; i++)
      begin
         if ((3'(i) < wcnt) && !guard_flag && ({addr[7:2], 2'(addr[1:0] + 2'(i))} >= guard_addr))
            page_hit = 1'b1;
      end
   end

   // the frame window stays open while in st_arm: select must fall before the next edge
   always_comb
   begin
      commit = 1'b0;
      if ((state == st_arm) && !pins_s.sel && unlocked)
      begin
         case (cmd_q)
            write_cmd: commit = guard_flag || (addr < guard_addr);
            page_program_cmd: commit = !page_hit;
            fill_all_cmd: commit = guard_flag;
            default: commit = 1'b0;
         endcase
      end
   end

   // ------------------------------------------------------------
   // serial sequencer and output shifter
   // ------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state <= st_idle;
         cnt <= 5'h00;
         hdr <= 10'h000;
         dat <= 16'h0000;
         wcnt <= 3'h0;
         cmd_q <= no_cmd;
         addr <= 8'h00;
         rd_word <= 16'h0000;
         idx <= 4'h0;
         rd_guard <= 1'b0;
         sdo <= 1'b0;
         sdo_oe_n <= 1'b1;
         ready_show <= 1'b0;
         prog_cnt <= 20'h00000;
         for (int i = 0; i < 4; i++)
            page_buf[i] <= 16'h0000;
      end
      else if (state == st_busy)
      begin
         // serial clock and data ignored until the programming cycle ends
         sdo <= 1'b0;
         sdo_oe_n <= ~pins_s.sel;
         prog_cnt <= prog_cnt - 20'h00001;
         if (prog_cnt == 20'h00001)
         begin
            state <= st_idle;
            ready_show <= 1'b1;
         end
      end
      else if (!pins_s.sel)
      begin
         sdo_oe_n <= 1'b1;
         ready_show <= 1'b0;
         state <= commit ? st_busy : st_idle;
         prog_cnt <= PROG_CYCLES[19:0];
      end
      else
      begin
         case (state)
            st_idle:
               state <= st_start;
            st_start:
            begin
               sdo <= 1'b1;
               sdo_oe_n <= ~ready_show;
               if (rise && pins_s.sdi)
               begin
                  state <= st_head;
                  cnt <= 5'h00;
                  hdr <= 10'h000;
                  ready_show <= 1'b0;
                  sdo_oe_n <= 1'b1;
               end
            end
            st_head:
            begin
               if (rise)
               begin
                  hdr <= next_hdr;
                  cnt <= cnt + 5'h01;
               end
               if (dec_fire)
               begin
                  addr <= a_in & amask;
                  cnt <= 5'h00;
                  wcnt <= 3'h0;
                  cmd_q <= cmd;
                  idx <= 4'hF;
                  state <= st_wait;
                  if (cmd == read_cmd)
                  begin
                     rd_word <= mem[a_in & amask];
                     rd_guard <= 1'b0;
                     sdo <= 1'b0;
                     sdo_oe_n <= 1'b0;
                     state <= st_read;
                  end
                  else if (cmd == guard_read_cmd)
                  begin
                     rd_word <= wide ? {guard_addr, guard_flag, 7'h00} : {guard_addr[5:0], guard_flag, 9'h000};
                     rd_guard <= 1'b1;
                     sdo <= 1'b0;
                     sdo_oe_n <= 1'b0;
                     state <= st_read;
                  end
                  else if ((cmd == write_cmd || cmd == page_program_cmd || cmd == fill_all_cmd) && wt_ok)
                     state <= st_data;
               end
            end
            st_data:
            begin
               if (rise)
               begin
                  dat <= next_dat;
                  cnt <= cnt + 5'h01;
                  if (cnt == `SED_LAST_DATA)
                  begin
                     page_buf[wcnt[1:0]] <= next_dat;
                     wcnt <= wcnt + 3'h1;
                     state <= st_arm;
                  end
               end
            end
            st_arm:
            begin
               // a further edge either starts the next page word or spoils the frame
               if (rise)
               begin
                  if (cmd_q == page_program_cmd && wcnt < `SED_PAGE_WORDS)
                  begin
                     dat <= next_dat;
                     cnt <= 5'h01;
                     state <= st_data;
                  end
                  else
                     state <= st_wait;
               end
            end
            st_read:
            begin
               if (rise)
               begin
                  sdo <= rd_word[idx];
                  idx <= idx - 4'h1;
                  if (idx == 4'h0 && !rd_guard)
                  begin
                     addr <= next_addr;
                     rd_word <= mem[next_addr];
                  end
               end
            end
            default:
               state <= state;
         endcase
      end
   end

   // ------------------------------------------------------------
   // lock and guard flags
   // ------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         unlocked <= 1'b0;
         armed <= 1'b0;
         otp <= 1'b0;
         guard_flag <= `SED_GUARD_FLAG_RST;
         guard_addr <= `SED_GUARD_ADDR_RST;
      end
      else if (dec_fire)
      begin
         armed <= 1'b0;
         case (cmd)
            program_unlock_cmd: unlocked <= unlocked | pins_s.permit;
            program_lock_cmd: unlocked <= 1'b0;
            guard_unlock_cmd: armed <= wt_ok & ~otp;
            guard_set_cmd:
            begin
               if (guard_ok)
               begin
                  guard_addr <= a_in & amask;
                  guard_flag <= 1'b0;
               end
            end
            guard_clear_cmd:
            begin
               if (guard_ok)
               begin
                  guard_addr <= `SED_GUARD_ADDR_RST;
                  guard_flag <= 1'b1;
               end
            end
            guard_freeze_cmd: otp <= otp | guard_ok;
            default: armed <= 1'b0;
         endcase
      end
   end

   // ------------------------------------------------------------
   // word array, written once when a programming cycle starts
   // ------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (commit)
      begin
         case (cmd_q)
            write_cmd: mem[addr] <= page_buf[0];
            page_program_cmd:
            begin
               // only the low two address bits roll within a page
               for (int i = 0; i < 4; i++)
               begin
                  if (3'(i) < wcnt)
                     mem[{addr[7:2], 2'(addr[1:0] + 2'(i))}] <= page_buf[i];
               end
            end
            default:
            begin
               for (int i = 0; i < 256; i++)
                  mem[i] <= page_buf[0];
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // register bus slave
   // ------------------------------------------------------------
   assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

   // one wait state; unmapped reads return zero and still acknowledge
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
         variant <= `SED_VARIANT_RST;
      end
      else
      begin
         wb_ack_o <= bus_req;
         wb_dat_o <= 32'h00000000;
         if (bus_req && wb_we_i && wb_adr_i == `SED_OFS_CTRL && wb_sel_i[0])
            variant <= wb_dat_i[1:0];
         if (bus_req && !wb_we_i)
         begin
            case (wb_adr_i)
               `SED_OFS_CTRL: wb_dat_o <= {30'h0, variant};
               `SED_OFS_STATUS: wb_dat_o <= {26'h0, state == st_busy, ready_show, armed, otp, guard_flag, unlocked};
               `SED_OFS_GUARD: wb_dat_o <= {24'h0, guard_addr};
               default: wb_dat_o <= 32'h00000000;
            endcase
         end
      end
   end

   assign sdo_o = sdo;
   assign sdo_oe_n_o = sdo_oe_n;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   a_reset_locks: assert property (@(posedge clk_i) $fell(rst_i) |-> !unlocked && state == st_idle)
      else $error("device not locked after power clear");

   a_start_opens: assert property (@(posedge clk_i) disable iff (rst_i)
      state == st_start && pins_s.sel && rise && pins_s.sdi |=> state == st_head && cnt == 5'h00)
      else $error("start bit did not open instruction");

   a_hiz_deselect: assert property (@(posedge clk_i) disable iff (rst_i)
      !pins_s.sel && state != st_busy |=> sdo_oe_n_o && state != st_read)
      else $error("output not released on deselect");

   a_dummy_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      dec_fire && pins_s.sel && cmd == read_cmd |=> !sdo_o && !sdo_oe_n_o && state == st_read && idx == 4'hF)
      else $error("read did not start with dummy zero");

   a_out_on_rise: assert property (@(posedge clk_i) disable iff (rst_i)
      state == st_read && $past(state) == st_read && $changed(sdo_o) |-> $past(rise))
      else $error("data out moved without clock edge");

   a_next_word: assert property (@(posedge clk_i) disable iff (rst_i)
      state == st_read && pins_s.sel && rise && idx == 4'h0 && !rd_guard |=> addr == $past(next_addr) && idx == 4'hF)
      else $error("sequential read did not advance");

   a_locked_discard: assert property (@(posedge clk_i) disable iff (rst_i)
      state != st_busy ##1 state == st_busy |-> $past(unlocked))
      else $error("programming started while locked");

   a_busy_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      state == st_busy && pins_s.sel && prog_cnt > 20'h00001 |=> !sdo_o && !sdo_oe_n_o)
      else $error("busy not shown on data out");

   a_guard_sequence: assert property (@(posedge clk_i) disable iff (rst_i)
      $changed(guard_addr) || $rose(otp) |-> $past(armed) && $past(dec_fire))
      else $error("guard changed without guard unlock");

   a_guard_flag: assert property (@(posedge clk_i) disable iff (rst_i)
      dec_fire && pins_s.sel && cmd == guard_set_cmd && guard_ok |=> !guard_flag && guard_addr == $past(a_in & amask))
      else $error("guard set did not take effect");

   a_unlock_holds: assert property (@(posedge clk_i) disable iff (rst_i)
      unlocked && !(dec_fire && cmd == program_lock_cmd) |=> unlocked)
      else $error("unlock lost without lock");

endmodule // sed_top

//--- test/sed_host.sv
// Purpose: host model driving the serial pins
// Assumes: caller enters each task just after a clk_i edge
// Notes: one serial bit spans 12 clk_i cycles
module sed_host
(
   input wire logic clk_i,
   input wire logic sdo_i,
   output logic sel_o,
   output logic sclk_o,
   output logic sdi_o,
   output logic guard_pin_o,
   output logic permit_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] rx = 32'h0;
   // deselected at power-up, serial clock parked low
   initial
   begin
      sel_o = 1'b0;
      sclk_o = 1'b0;
      sdi_o = 1'b0;
      guard_pin_o = 1'b0;
      permit_o = 1'b1;
   end
   // pin levels for the next instruction
   task automatic mode(input logic g, input logic p);
      guard_pin_o <= g;
      permit_o <= p;
   endtask
   // clock is low here, so select rises cleanly
   task automatic open();
      sel_o <= 1'b1;
      repeat (6) @(posedge clk_i);
   endtask
   // exact bit count per call, reply sampled late in the high half
   task automatic shift(input logic [31:0] v, input int n);
      for (int i = n - 1; i >= 0; i--)
      begin
         sdi_o <= v[i];
         repeat (6) @(posedge clk_i);
         sclk_o <= 1'b1;
         repeat (6) @(posedge clk_i);
         rx = {rx[30:0], sdo_i};
         sclk_o <= 1'b0;
      end
   endtask
   // data line flips so a stale level is never trusted
   task automatic close();
      sel_o <= 1'b0;
      sdi_o <= ~sdi_o;
      repeat (10) @(posedge clk_i);
   endtask
endmodule // sed_host

//--- test/sed_top_tb.sv
// Purpose: self-checking bench for the serial eeprom decoder
// Assumes: six-bit addresses unless a scenario sets the variant
// Notes: programming time shortened to 50 clocks
`include "sed_consts.svh"
module sed_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [3:0] adr = 4'h0;
   logic [31:0] wdat = 32'h0, rdat, r;
   logic ack, sel, sclk, sdi, gp, pm, sdo, oe_n;
   // a released data line shows the inverse, so the host never trusts a stale level
   wire q_line = oe_n ? ~sdo : sdo;
   int fails = 0, comparisons = 0;
   sed_host i_host (.clk_i(clk), .sdo_i(q_line), .sel_o(sel), .sclk_o(sclk), .sdi_o(sdi), .guard_pin_o(gp),
      .permit_o(pm));
   sed_top #(.PROG_CYCLES(50)) i_dut (.clk_i(clk), .rst_i(rst), .sel_i(sel), .sclk_i(sclk), .sdi_i(sdi),
      .guard_pin_i(gp), .permit_i(pm), .sdo_o(sdo), .sdo_oe_n_o(oe_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
   // clock and the main sequence
   initial forever #20 clk = ~clk;
   initial
   begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      s_regs();
      s_write();
      s_medium();
      s_guard();
      s_lock();
      summarize();
   end
   task automatic summarize();
      if (fails == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         fails++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // classic single cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      for (int n = 0; n < 40; n++)
      begin
         @(posedge clk);
         if (ack === 1'b1)
            break;
      end
      r = rdat;
      check(ack, 1'b1);
      if (ack !== 1'b1)
         summarize();
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask
   task automatic cmd(input logic [31:0] v, input int n);
      i_host.open();
      i_host.shift(v, n);
      i_host.close();
   endtask
   task automatic rd(input logic [31:0] v, input int n);
      i_host.open();
      i_host.shift(v, n);
      i_host.shift(32'h0, 16);
      r = i_host.rx;
      i_host.close();
   endtask
   // select during programming shows busy, then ready; bounded poll
   // with no cycle started the line stays released
   task automatic prog(input logic busy);
      i_host.open();
      repeat (8) @(posedge clk);
      check({oe_n, sdo}, {!busy, !busy});
      for (int n = 0; n < 100 && sdo !== 1'b1; n++)
         @(posedge clk);
      check(sdo, 1'b1);
      if (sdo !== 1'b1)
         summarize();
      i_host.close();
   endtask
   task automatic s_regs();
      wb(1'b0, `SED_OFS_STATUS, 32'h0);
      check(r[1:0], 2'b10);
      wb(1'b1, `SED_OFS_CTRL, 32'h0);
      wb(1'b0, 4'hC, 32'h0);
      check(r, 32'h0);
      cmd({1'b1, 2'b01, 6'h05, 16'hDEAD}, 25);
      prog(1'b0);
   endtask
   task automatic s_write();
      cmd(9'b1_00_110000, 9);
      wb(1'b0, `SED_OFS_STATUS, 32'h0);
      check(r[0], 1'b1);
      cmd({1'b1, 2'b01, 6'h05, 16'hA5C3}, 25);
      prog(1'b1);
      cmd({1'b1, 2'b01, 6'h06, 16'h0F0F}, 25);
      prog(1'b1);
      i_host.open();
      i_host.shift({1'b1, 2'b11, 6'h08, 16'h1111}, 25);
      i_host.shift(32'h2222, 16);
      i_host.close();
      prog(1'b1);
      rd({1'b1, 2'b10, 6'h09}, 9);
      check(r[15:0], 16'h2222);
      // leading zeros before the start bit, then a two-word stream
      i_host.open();
      i_host.shift({3'b001, 2'b10, 6'h05}, 11);
      check({oe_n, i_host.rx[0]}, 2'b00);
      i_host.shift(32'h0, 16);
      check(i_host.rx[15:0], 16'hA5C3);
      i_host.shift(32'h0, 16);
      check(i_host.rx[15:0], 16'h0F0F);
      i_host.shift(32'h0, 3);
      i_host.close();
      check(oe_n, 1'b1);
   endtask
   task automatic s_medium();
      wb(1'b1, `SED_OFS_CTRL, 32'h1);
      cmd({1'b1, 2'b01, 8'h87, 16'h1234}, 27);
      prog(1'b1);
      rd({1'b1, 2'b10, 8'h07}, 11);
      check(r[15:0], 16'h1234);
      wb(1'b1, `SED_OFS_CTRL, 32'h0);
   endtask
   task automatic s_guard();
      i_host.mode(1'b1, 1'b1);
      cmd(9'b1_00_110000, 9);
      cmd(9'b1_01_010000, 9);
      i_host.open();
      i_host.shift(9'b1_10_000000, 9);
      i_host.shift(32'h0, 7);
      i_host.close();
      check(i_host.rx[7:0], 8'h20);
      cmd(9'b1_11_111111, 9);
      wb(1'b0, `SED_OFS_GUARD, 32'h0);
      check(r[7:0], 8'h10);
      i_host.mode(1'b0, 1'b1);
      cmd({1'b1, 2'b01, 6'h10, 16'hBEEF}, 25);
      prog(1'b0);
      cmd({1'b1, 2'b00, 6'h10, 16'h0}, 25);
      prog(1'b0);
      cmd({1'b1, 2'b01, 6'h0F, 16'h5A5A}, 25);
      prog(1'b1);
      // a fresh guard unlock lets clear through, another one lets freeze through
      i_host.mode(1'b1, 1'b1);
      cmd(9'b1_00_110000, 9);
      cmd(9'b1_11_111111, 9);
      wb(1'b0, `SED_OFS_GUARD, 32'h0);
      check(r[7:0], 8'hFF);
      cmd(9'b1_00_110000, 9);
      cmd(9'b1_00_000000, 9);
      wb(1'b0, `SED_OFS_STATUS, 32'h0);
      check(r[3:0], 4'h7);
      i_host.mode(1'b0, 1'b1);
   endtask
   task automatic s_lock();
      cmd(9'b1_00_000000, 9);
      cmd({1'b1, 2'b01, 6'h05, 16'hFFFF}, 25);
      prog(1'b0);
      rd({1'b1, 2'b10, 6'h05}, 9);
      check(r[15:0], 16'hA5C3);
   endtask
endmodule // sed_top_tb
